/* verilog/fpbm_pkg.sv */
package fpbm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_HZ = 32_768;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int unsigned ERASE_IGN_MS = 100;
  localparam int unsigned ERASE_TRIG_MS = 220;
  localparam int unsigned ERASE_IGN_TICKS = (ERASE_IGN_MS * SLOW_HZ + 999) / 1000;
  localparam int unsigned ERASE_TRIG_TICKS = (ERASE_TRIG_MS * SLOW_HZ + 999) / 1000;
  localparam int unsigned PROG_ERASE_US = 4600;
  localparam int unsigned PROG_US = 2300;
  localparam int unsigned FULL_ERASE_US = 10000;
  localparam int unsigned PROG_ERASE_CYC = PROG_ERASE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PROG_CYC = PROG_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FULL_ERASE_CYC = FULL_ERASE_US * (CLK_HZ / 1_000_000);
  // ----------------------------------------
  // Memory map
  // ----------------------------------------
  localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
  localparam logic [31:0] CORE_BASE = 32'h0020_0000;
  localparam logic [31:0] WIN_BASE = 32'h002f_f000;
  localparam logic [31:0] BACKUP_BASE = 32'h0030_0000;
  localparam logic [31:0] ROM_BASE = 32'h0040_0000;
  localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
  localparam logic [16:0] FLASH_BYTES_M1 = 17'h1_ffff;
  localparam logic [16:0] CORE_BYTES_M1 = 17'h0_0fff;
  localparam logic [16:0] BACKUP_BYTES_M1 = 17'h0_07ff;
  localparam logic [16:0] ROM_BYTES_M1 = 17'h0_2fff;
  localparam int unsigned PAGE_W = 9;
  localparam int unsigned LOCKS = 16;
  localparam int unsigned REGION_LSB = 5;
  localparam int unsigned WBUF_WORDS = 32;
  // Select one-hot positions
  localparam int unsigned SEL_FLASH = 0;
  localparam int unsigned SEL_ROM = 1;
  localparam int unsigned SEL_CORE = 2;
  localparam int unsigned SEL_BACKUP = 3;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOCK = 8'h08;
  localparam logic [7:0] REG_REMAP = 8'h0c;
  localparam logic [7:0] REG_CALIB = 8'h10;
  localparam logic [7:0] REG_WBUF = 8'h80;
  localparam int unsigned CMD_ARG_LSB = 8;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_LOCKERR_BIT = 1;
  localparam int unsigned ST_SEC_BIT = 2;
  localparam int unsigned ST_BOOT_BIT = 3;
  localparam int unsigned ST_REMAP_BIT = 4;
  localparam int unsigned ST_FPM_BIT = 5;
  localparam int unsigned ST_ERASEPIN_BIT = 6;
  localparam int unsigned GENERAL_PURPOSE_NVM_BIT_SEC = 0;
  localparam int unsigned GENERAL_PURPOSE_NVM_BIT_BOOT = 1;
  localparam logic [15:0] LOCK_RST = 16'h0000;
  localparam logic [1:0] GENERAL_PURPOSE_NVM_BIT_RST = 2'h0;
  localparam logic [15:0] CALIB_DEF = 16'h0000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [7:0] {
    CMD_PROG_ERASE = 8'h01,
    CMD_PROG = 8'h02,
    CMD_ERASE_ALL = 8'h05,
    CMD_SET_LOCK = 8'h08,
    CMD_CLR_LOCK = 8'h09,
    CMD_SET_GENERAL_PURPOSE_NVM_BIT = 8'h0b,
    CMD_CLR_GENERAL_PURPOSE_NVM_BIT = 8'h0c
  } fpbm_cmd_type;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PROG_ERASE = 2'h1,
    OP_PROG = 2'h2,
    OP_FULL_ERASE = 2'h3
  } fpbm_op_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_FIN = 2'h3
  } fpbm_state_type;
endpackage

/* verilog/fpbm_erase_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fpbm_erase_if;
  logic pin;
  logic fire;
  logic held;
  modport top (output pin, input fire, input held);
  modport dbnc (input pin, output fire, output held);
endinterface
`default_nettype wire

/* verilog/fpbm_erase_dbnc.sv */
`timescale 1ns/1ps
`default_nettype none
module fpbm_erase_dbnc
  import fpbm_pkg::*;
#(
  parameter int unsigned DIV = SLOW_DIV,
  parameter int unsigned IGN = ERASE_IGN_TICKS,
  parameter int unsigned TRIG = ERASE_TRIG_TICKS
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  fpbm_erase_if.dbnc er
);
  logic [15:0] div_r;
  logic [15:0] cnt_r;
  logic tick;
  logic fire_r;
  logic held_r;

  // ----------------------------------------
  // Slow clock enable
  // ----------------------------------------
  assign tick = (div_r == 16'(DIV - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      div_r <= 16'h0000;
    end else if (tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Hold counter
  // ----------------------------------------
  // Counter parks at the trigger count so a long hold fires only once
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_r <= 16'h0000;
    end else if (!er.pin) begin
      cnt_r <= 16'h0000;
    end else if (tick && cnt_r != 16'(TRIG)) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fire_r <= 1'b0;
      held_r <= 1'b0;
    end else begin
      fire_r <= er.pin && tick && cnt_r == 16'(TRIG - 1);
      held_r <= er.pin && cnt_r >= 16'(IGN);
    end
  end

  assign er.fire = fire_r;
  assign er.held = held_r;
endmodule
`default_nettype wire

/* verilog/fpbm_top.sv */
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fpbm_top
  import fpbm_pkg::*;
#(
  parameter int unsigned P_SLOW_DIV = SLOW_DIV,
  parameter int unsigned P_IGN_TICKS = ERASE_IGN_TICKS,
  parameter int unsigned P_TRIG_TICKS = ERASE_TRIG_TICKS,
  parameter int unsigned P_PROG_ERASE_CYC = PROG_ERASE_CYC,
  parameter int unsigned P_PROG_CYC = PROG_CYC,
  parameter int unsigned P_FULL_ERASE_CYC = FULL_ERASE_CYC,
  parameter logic [15:0] P_CALIB = CALIB_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [31:0] sys_addr_i,
  output logic [3:0] sys_sel_o,
  output logic [16:0] sys_offset_o,
  output logic sys_unmapped_o,
  output logic [12:0] flash_line_addr_o,
  input wire logic [127:0] flash_line_i,
  output logic [31:0] flash_word_o,
  output logic [1:0] flash_op_o,
  output logic [8:0] flash_page_o,
  input wire logic [4:0] flash_wbuf_idx_i,
  output logic [31:0] flash_wbuf_word_o,
  output logic flash_irq_o,
  input wire logic dbg_req_i,
  input wire logic ffp_req_i,
  output logic dbg_grant_o,
  output logic ffp_grant_o,
  input wire logic erase_pin_i,
  input wire logic factory_test_pin_i,
  input wire logic external_clock_input_i,
  input wire logic wakeup_pin_i,
  output logic fast_prog_mode_o,
  output logic boot_select_nvm_bit_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic fpm_r;
  logic [15:0] lock_r;
  logic [1:0] general_purpose_nvm_bit_r;
  logic remap_r;
  logic lock_err_r;
  logic erase_run_r;
  fpbm_state_type state_r;
  fpbm_op_type op_r;
  logic [8:0] page_r;
  logic [19:0] timer_r;
  logic [31:0] wbuf_r [WBUF_WORDS];
  logic [31:0] wbuf_word_r;
  logic [3:0] sel_r;
  logic [16:0] off_r;
  logic unmap_r;
  logic [31:0] fword_r;
  logic dbg_gnt_r;
  logic ffp_gnt_r;
  logic cmd_go;
  logic [7:0] opc;
  logic [8:0] arg;
  logic [3:0] region;
  logic is_prog;
  logic abort;
  fpbm_erase_if er ();

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {wakeup_pin_i, external_clock_input_i, factory_test_pin_i, erase_pin_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign er.pin = pin_s2_r[0];

  fpbm_erase_dbnc #(
    .DIV(P_SLOW_DIV),
    .IGN(P_IGN_TICKS),
    .TRIG(P_TRIG_TICKS)
  ) u_dbnc (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .er(er)
  );

  // ----------------------------------------
  // Fast programming straps
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fpm_r <= 1'b0;
    end else begin
      fpm_r <= pin_s2_r[1] && pin_s2_r[2] && !pin_s2_r[3];
    end
  end

  // ----------------------------------------
  // Avalon slave handshake
  // ----------------------------------------
  // One wait cycle: request seen, then waitrequest low for exactly one cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wait_r <= 1'b1;
    end else if (wait_r && (avs_read_i || avs_write_i)) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign wr_acc = !wait_r && avs_write_i;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_i >= REG_WBUF) begin
      rd_mux = wbuf_r[avs_address_i[6:2]];
    end else begin
      unique case (avs_address_i)
        REG_CMD: rd_mux = {23'h00_0000, page_r};
        REG_STATUS: begin
          rd_mux[ST_BUSY_BIT] = (state_r != ST_IDLE);
          rd_mux[ST_LOCKERR_BIT] = lock_err_r;
          rd_mux[ST_SEC_BIT] = general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_SEC];
          rd_mux[ST_BOOT_BIT] = general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_BOOT];
          rd_mux[ST_REMAP_BIT] = remap_r;
          rd_mux[ST_FPM_BIT] = fpm_r;
          rd_mux[ST_ERASEPIN_BIT] = er.held;
        end
        REG_LOCK: rd_mux = {16'h0000, lock_r};
        REG_REMAP: rd_mux = {31'h0000_0000, remap_r};
        REG_CALIB: rd_mux = {16'h0000, P_CALIB};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (wait_r && avs_read_i) begin
      rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------
  // Write buffer
  // ----------------------------------------
  // Kept out of reset: contents are data, not control
  always_ff @(posedge clk_sys_i) begin
    if (wr_acc && avs_address_i >= REG_WBUF) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable_i[b]) begin
          wbuf_r[avs_address_i[6:2]][8*b +: 8] <= avs_writedata_i[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wbuf_word_r <= 32'h0000_0000;
    end else begin
      wbuf_word_r <= wbuf_r[flash_wbuf_idx_i];
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign opc = avs_writedata_i[7:0];
  assign arg = avs_writedata_i[CMD_ARG_LSB +: PAGE_W];
  assign region = arg[REGION_LSB +: 4];
  assign cmd_go = wr_acc && avs_address_i == REG_CMD && state_r == ST_IDLE && !er.fire;
  assign is_prog = (opc == CMD_PROG_ERASE) || (opc == CMD_PROG);
  assign abort = (is_prog && lock_r[region]) || (opc == CMD_ERASE_ALL && |lock_r);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Erase pin wins over any running command so a stuck part can recover
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      op_r <= OP_NONE;
      page_r <= 9'h000;
      timer_r <= 20'h0_0000;
      erase_run_r <= 1'b0;
    end else if (er.fire) begin
      state_r <= ST_BUSY;
      op_r <= OP_FULL_ERASE;
      timer_r <= 20'(P_FULL_ERASE_CYC);
      erase_run_r <= 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_go && !abort) begin
            if (opc == CMD_PROG_ERASE) begin
              state_r <= ST_BUSY;
              op_r <= OP_PROG_ERASE;
              page_r <= arg;
              timer_r <= 20'(P_PROG_ERASE_CYC);
            end else if (opc == CMD_PROG) begin
              state_r <= ST_BUSY;
              op_r <= OP_PROG;
              page_r <= arg;
              timer_r <= 20'(P_PROG_CYC);
            end else if (opc == CMD_ERASE_ALL) begin
              state_r <= ST_BUSY;
              op_r <= OP_FULL_ERASE;
              timer_r <= 20'(P_FULL_ERASE_CYC);
            end
          end
        end
        ST_BUSY: begin
          timer_r <= timer_r - 20'h0_0001;
          if (timer_r == 20'h0_0001) begin
            state_r <= ST_FIN;
          end
        end
        ST_FIN: begin
          state_r <= ST_IDLE;
          op_r <= OP_NONE;
          erase_run_r <= 1'b0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Lock bits and abort flag
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      lock_r <= LOCK_RST;
    end else if (er.fire) begin
      lock_r <= 16'h0000;
    end else if (cmd_go && opc == CMD_SET_LOCK) begin
      lock_r[region] <= 1'b1;
    end else if (cmd_go && opc == CMD_CLR_LOCK) begin
      lock_r[region] <= 1'b0;
    end
  end

  // A fresh command clears the flag, but its own abort sets it again
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      lock_err_r <= 1'b0;
    end else if (cmd_go && abort) begin
      lock_err_r <= 1'b1;
    end else if (cmd_go) begin
      lock_err_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // General-purpose bits and remap
  // ----------------------------------------
  // Security can not be cleared by command; only the pin-driven erase does it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      general_purpose_nvm_bit_r <= GENERAL_PURPOSE_NVM_BIT_RST;
    end else if (er.fire) begin
      general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_BOOT] <= 1'b0;
    end else if (state_r == ST_FIN && erase_run_r) begin
      general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_SEC] <= 1'b0;
    end else if (cmd_go && opc == CMD_SET_GENERAL_PURPOSE_NVM_BIT) begin
      general_purpose_nvm_bit_r[arg[0]] <= 1'b1;
    end else if (cmd_go && opc == CMD_CLR_GENERAL_PURPOSE_NVM_BIT && arg[0]) begin
      general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_BOOT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      remap_r <= 1'b0;
    end else if (wr_acc && avs_address_i == REG_REMAP && avs_writedata_i[0]) begin
      remap_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sel_r <= 4'h0;
      off_r <= 17'h0_0000;
      unmap_r <= 1'b0;
    end else begin
      sel_r <= 4'h0;
      off_r <= sys_addr_i[16:0];
      unmap_r <= 1'b0;
      if (sys_addr_i[31:20] == BOOT_BASE[31:20]) begin
        if (remap_r) begin
          sel_r[SEL_CORE] <= 1'b1;
          unmap_r <= sys_addr_i[19:0] > 20'(CORE_BYTES_M1);
        end else if (general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_BOOT]) begin
          sel_r[SEL_FLASH] <= 1'b1;
          unmap_r <= sys_addr_i[19:0] > 20'(FLASH_BYTES_M1);
        end else begin
          sel_r[SEL_ROM] <= 1'b1;
          unmap_r <= sys_addr_i[19:0] > 20'(ROM_BYTES_M1);
        end
      end else if (sys_addr_i[31:20] == FLASH_BASE[31:20]) begin
        sel_r[SEL_FLASH] <= 1'b1;
        unmap_r <= sys_addr_i[19:0] > 20'(FLASH_BYTES_M1);
      end else if (sys_addr_i[31:12] == CORE_BASE[31:12]) begin
        sel_r[SEL_CORE] <= 1'b1;
      end else if (sys_addr_i[31:12] == WIN_BASE[31:12]) begin
        sel_r[SEL_CORE] <= 1'b1;
      end else if (sys_addr_i[31:11] == BACKUP_BASE[31:11]) begin
        sel_r[SEL_BACKUP] <= 1'b1;
      end else if (sys_addr_i[31:20] == ROM_BASE[31:20]) begin
        sel_r[SEL_ROM] <= 1'b1;
        unmap_r <= sys_addr_i[19:0] > 20'(ROM_BYTES_M1);
      end else begin
        unmap_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Wide array read
  // ----------------------------------------
  // One 128-bit line feeds four bus words; word picked by the decoded offset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fword_r <= 32'h0000_0000;
    end else begin
      fword_r <= flash_line_i[32*off_r[3:2] +: 32];
    end
  end

  // ----------------------------------------
  // Debug and fast-port gating
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      dbg_gnt_r <= 1'b0;
      ffp_gnt_r <= 1'b0;
    end else begin
      dbg_gnt_r <= dbg_req_i && !general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_SEC];
      ffp_gnt_r <= ffp_req_i && fpm_r && !general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_SEC];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign sys_sel_o = sel_r;
  assign sys_offset_o = off_r;
  assign sys_unmapped_o = unmap_r;
  assign flash_line_addr_o = off_r[16:4];
  assign flash_word_o = fword_r;
  assign flash_op_o = op_r;
  assign flash_page_o = page_r;
  assign flash_wbuf_word_o = wbuf_word_r;
  assign flash_irq_o = lock_err_r;
  assign dbg_grant_o = dbg_gnt_r;
  assign ffp_grant_o = ffp_gnt_r;
  assign fast_prog_mode_o = fpm_r;
  assign boot_select_nvm_bit_o = general_purpose_nvm_bit_r[GENERAL_PURPOSE_NVM_BIT_BOOT];
endmodule
`default_nettype wire

/* tb/fpbm_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fpbm_top_asserts
  import fpbm_pkg::*;
#(
  parameter int unsigned P_PROG_CYC = PROG_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] sys_addr_i,
  input wire logic [3:0] sys_sel_o,
  input wire logic [1:0] flash_op_o,
  input wire logic flash_irq_o,
  input wire logic factory_test_pin_i,
  input wire logic external_clock_input_i,
  input wire logic wakeup_pin_i,
  input wire logic fast_prog_mode_o,
  input wire logic boot_select_nvm_bit_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic cmd_done;
  logic [15:0] prog_cnt_r;
  assign cmd_done = avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CMD;
  // Counter keeps the length check free of long repetitions
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || flash_op_o != OP_PROG) prog_cnt_r <= 16'h0000;
    else prog_cnt_r <= prog_cnt_r + 16'h0001;
  end
  sequence req_waiting;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence pins_steady;
    $stable({factory_test_pin_i, external_clock_input_i, wakeup_pin_i}) [*5];
  endsequence
  a_wait_answer: assert property (req_waiting |=> !avs_waitrequest_o)
    else $error("waitrequest late");
  a_rom_fixed: assert property (sys_addr_i >= ROM_BASE && sys_addr_i <= ROM_BASE + 32'h2fff
    |=> sys_sel_o == 4'h2) else $error("rom not selected");
  a_flash_fixed: assert property (sys_addr_i >= FLASH_BASE && sys_addr_i <= FLASH_BASE + 32'h1ffff
    |=> sys_sel_o == 4'h1) else $error("flash not selected");
  a_sram_window: assert property (sys_addr_i >= WIN_BASE && sys_addr_i <= BACKUP_BASE + 32'h7ff
    |=> sys_sel_o == ($past(sys_addr_i) < BACKUP_BASE ? 4'h4 : 4'h8)) else $error("sram window");
  a_boot_area: assert property (sys_addr_i < 32'h1000 |=> sys_sel_o == 4'h4 ||
    sys_sel_o == ($past(boot_select_nvm_bit_o) ? 4'h1 : 4'h2)) else $error("area zero");
  a_irq_cause: assert property ($rose(flash_irq_o) |-> $past(cmd_done) || $past(cmd_done, 2))
    else $error("irq without command");
  a_fast_entry: assert property (pins_steady |-> fast_prog_mode_o ==
    (factory_test_pin_i && external_clock_input_i && !wakeup_pin_i)) else $error("fast mode");
  a_prog_length: assert property ($fell(flash_op_o == OP_PROG) |-> prog_cnt_r >= P_PROG_CYC
    && prog_cnt_r <= P_PROG_CYC + 2) else $error("program length");
endmodule
bind fpbm_top fpbm_top_asserts #(.P_PROG_CYC(P_PROG_CYC)) fpbm_top_asserts_inst (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .sys_addr_i(sys_addr_i), .sys_sel_o(sys_sel_o), .flash_op_o(flash_op_o),
  .flash_irq_o(flash_irq_o), .factory_test_pin_i(factory_test_pin_i),
  .external_clock_input_i(external_clock_input_i), .wakeup_pin_i(wakeup_pin_i),
  .fast_prog_mode_o(fast_prog_mode_o), .boot_select_nvm_bit_o(boot_select_nvm_bit_o));
`default_nettype wire

/* tb/fpbm_sys_master.sv */
`timescale 1ns/1ps
`default_nettype none
module fpbm_sys_master (
  input wire logic clk_sys_i,
  input wire logic [31:0] want_i,
  input wire logic [12:0] line_addr_i,
  output logic [31:0] sys_addr_o,
  output logic [127:0] line_o
);
  // Master puts a new address out on each clock
  always @(posedge clk_sys_i) sys_addr_o <= want_i;
  // Array stand-in: each word names its own line and lane
  always_comb begin
    for (int k = 0; k < 4; k++) line_o[k*32 +: 32] = {8'h5a, 3'h0, line_addr_i, 6'h0, k[1:0]};
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpbm_pkg::*;
  localparam logic [15:0] CAL = 16'h5a3c;
  logic clk_sys_i, rst_b_i, rd, wr, dbg, ffp, erase, tst, cki, wup, wt, unm, irq, dgr, fgr, fpm, boot;
  logic [7:0] adr;
  logic [31:0] wd, want, sa, rdata, word, wword, a;
  logic [3:0] be, sel;
  logic [4:0] widx;
  logic [16:0] off;
  logic [12:0] la;
  logic [127:0] line;
  logic [1:0] op;
  logic [8:0] page;
  logic [31:0] q[$];
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] base [9] = '{32'h0, FLASH_BASE, CORE_BASE, WIN_BASE, BACKUP_BASE, ROM_BASE,
    32'h00403000, 32'h00300800, 32'h00201000};
  logic [31:0] msk [9] = '{32'hffc, 32'h1fffc, 32'hffc, 32'hffc, 32'h7fc, 32'h2ffc, 0, 0, 0};
  logic [3:0] sl [9] = '{4'h2, 4'h1, 4'h4, 4'h4, 4'h8, 4'h2, 4'h2, 4'h0, 4'h0};
  fpbm_top #(.P_SLOW_DIV(4), .P_IGN_TICKS(2), .P_TRIG_TICKS(5), .P_PROG_ERASE_CYC(20),
    .P_PROG_CYC(10), .P_FULL_ERASE_CYC(40), .P_CALIB(CAL)) fpbm_top_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .sys_addr_i(sa), .sys_sel_o(sel), .sys_offset_o(off),
    .sys_unmapped_o(unm), .flash_line_addr_o(la), .flash_line_i(line), .flash_word_o(word),
    .flash_op_o(op), .flash_page_o(page), .flash_wbuf_idx_i(widx), .flash_wbuf_word_o(wword),
    .flash_irq_o(irq), .dbg_req_i(dbg), .ffp_req_i(ffp), .dbg_grant_o(dgr), .ffp_grant_o(fgr),
    .erase_pin_i(erase), .factory_test_pin_i(tst), .external_clock_input_i(cki),
    .wakeup_pin_i(wup), .fast_prog_mode_o(fpm), .boot_select_nvm_bit_o(boot));
  fpbm_sys_master fpbm_sys_master_inst (.clk_sys_i(clk_sys_i), .want_i(want),
    .line_addr_i(la), .sys_addr_o(sa), .line_o(line));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    rd <= !w; wr <= w; adr <= ad; wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (wt === 1'b0) break;
    end
    rd <= 1'b0; wr <= 1'b0;
    if (i == 20) begin n_errors++; report_and_stop(); end
  endtask
  task automatic rdq(input logic [7:0] ad, input logic [31:0] exp);
    q.push_back(exp);
    bus(1'b0, ad, 32'h0);
  endtask
  task automatic dec(input logic [31:0] ad, input logic [3:0] s, input logic u = 1'b0);
    want <= ad;
    repeat (4) @(posedge clk_sys_i);
    chk({10'h0, sel, unm, off}, {10'h0, s, u, ad[16:0]});
    if (s == 4'h1) chk(word, {8'h5a, 3'h0, ad[16:4], 6'h0, ad[3:2]});
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys_i);
      if (op === OP_NONE) break;
    end
    if (i == 200) begin n_errors++; report_and_stop(); end
    repeat (2) @(posedge clk_sys_i);
  endtask
  // Read results are matched against the oldest expectation
  always @(posedge clk_sys_i) begin
    if (rd === 1'b1 && wt === 1'b0 && q.size() > 0) chk(rdata, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst_b_i = 0; rd = 0; wr = 0; adr = 0; wd = 0; be = 4'hf; want = 0; widx = 0;
    dbg = 0; ffp = 0; erase = 0; tst = 0; cki = 0; wup = 0;
    void'($urandom(32'h09992d7f));
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rdq(REG_STATUS, 32'h0);
    rdq(REG_LOCK, 32'h0);
    bus(1'b1, REG_CALIB, 32'hffff);
    rdq(REG_CALIB, {16'h0, CAL});
    rdq(8'h20, 32'h0);
    for (int i = 0; i < 9; i++) dec(base[i] + ($urandom & msk[i]), sl[i], i > 5);
    a = $urandom;
    bus(1'b1, REG_WBUF + 8'h04, a);
    widx <= 5'h01;
    rdq(REG_WBUF + 8'h04, a);
    chk(wword, a);
    be <= 4'h1;
    bus(1'b1, REG_WBUF + 8'h04, ~a);
    be <= 4'hf;
    rdq(REG_WBUF + 8'h04, {a[31:8], ~a[7:0]});
    bus(1'b1, REG_CMD, 32'h6008);
    rdq(REG_LOCK, 32'h8);
    bus(1'b1, REG_CMD, 32'h7f02);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq}, 32'h1);
    rdq(REG_STATUS, 32'h2);
    bus(1'b1, REG_CMD, 32'h8002);
    repeat (2) @(posedge clk_sys_i);
    chk({21'h0, op, page}, {21'h0, OP_PROG, 9'h080});
    wait_idle();
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, REG_CMD, 32'h6009);
    rdq(REG_LOCK, 32'h0);
    bus(1'b1, REG_CMD, 32'h0005);
    repeat (2) @(posedge clk_sys_i);
    chk({30'h0, op}, {30'h0, OP_FULL_ERASE});
    wait_idle();
    bus(1'b1, REG_CMD, 32'h010b);
    dec(32'h0, 4'h1);
    bus(1'b1, REG_REMAP, 32'h1);
    dec(32'h0, 4'h4);
    dec(CORE_BASE, 4'h4);
    tst <= 1; cki <= 1; dbg <= 1; ffp <= 1;
    repeat (6) @(posedge clk_sys_i);
    chk({29'h0, fpm, dgr, fgr}, 32'h7);
    wup <= 1;
    repeat (6) @(posedge clk_sys_i);
    chk({31'h0, fpm}, 32'h0);
    wup <= 0;
    bus(1'b1, REG_CMD, 32'h000b);
    bus(1'b1, REG_CMD, 32'h000c);
    repeat (6) @(posedge clk_sys_i);
    chk({30'h0, dgr, fgr}, 32'h0);
    rdq(REG_STATUS, 32'h3c);
    bus(1'b1, REG_CMD, 32'h6008);
    erase <= 1;
    repeat (8) @(posedge clk_sys_i);
    erase <= 0;
    repeat (30) @(posedge clk_sys_i);
    chk({31'h0, boot}, 32'h1);
    erase <= 1;
    repeat (60) @(posedge clk_sys_i);
    erase <= 0;
    wait_idle();
    rdq(REG_LOCK, 32'h0);
    chk({31'h0, boot}, 32'h0);
    rdq(REG_STATUS, 32'h30);
    rdq(REG_CALIB, {16'h0, CAL});
    chk({30'h0, dgr, fgr}, 32'h3);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rdq(REG_REMAP, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
